/* File: core/cwp_pkg.sv */
package cwp_pkg;

  // CW clock modes; the multiple on the high-rate pin
  typedef enum logic [2:0] {
    CWP_M16 = 3'h0,
    CWP_M32 = 3'h1,
    CWP_M8  = 3'h2,
    CWP_M4  = 3'h3,
    CWP_M1  = 3'h4
  } cwp_mode_t;

  localparam int CWP_CHANNELS = 8;
  localparam int CWP_PHASES   = 16;
  localparam int CWP_SEL_W    = 4;
  localparam int CWP_WGT_W    = 5;

  // Pin positions in the synchroniser vector
  localparam int CWP_PIN_MULT = 0;
  localparam int CWP_PIN_SYNC = 1;
  localparam int CWP_PIN_SCLK = 2;
  localparam int CWP_PIN_SDIN = 3;
  localparam int CWP_PIN_LE   = 4;
  localparam int CWP_PIN_N    = 5;

  // Serial configuration frame, first bit shifted in is the msb
  localparam int CWP_FRAME_W  = 36;
  localparam int CWP_F_MODE   = 33;
  localparam int CWP_F_HS     = 32;
  localparam int CWP_F_SEL    = 0;

  // Values after reset
  localparam cwp_mode_t CWP_MODE_RST = CWP_M16;
  localparam logic CWP_HS_RST        = 1'b1;
  localparam logic [3:0] CWP_SEL_RST = 4'h0;

  // Phase advance per counted edge, in sixteenths of a carrier period
  localparam logic [3:0] CWP_STEP_16 = 4'h1;
  localparam logic [3:0] CWP_STEP_8  = 4'h2;
  localparam logic [3:0] CWP_STEP_4  = 4'h4;
  localparam logic [3:0] CWP_QUARTER = 4'h4;

endpackage

/* File: core/cwp_phase_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cwp_phase_if;
  cwp_pkg::cwp_mode_t mode;
  logic               mult_edge;
  logic               sync_edge;
  logic [3:0]         phase;

  modport gen (
    input  mode,
    input  mult_edge,
    input  sync_edge,
    output phase
  );

  modport use_side (
    output mode,
    output mult_edge,
    output sync_edge,
    input  phase
  );
endinterface
`default_nettype wire

/* File: core/cwp_phase_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module cwp_phase_gen (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Phase link
  cwp_phase_if.gen pl
);

  logic       half;
  logic [3:0] step;
  logic       count_en;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Step per counted edge: quadrature modes walk the same 16-step circle
  always_comb begin
    case (pl.mode)
      cwp_pkg::CWP_M8: step = cwp_pkg::CWP_STEP_8;
      cwp_pkg::CWP_M4: step = cwp_pkg::CWP_STEP_4;
      default:         step = cwp_pkg::CWP_STEP_16;
    endcase
  end

  // Divide by two ahead of the 16x generator
  always_ff @(posedge core_clk) begin
    if (rst || pl.sync_edge) begin
      half <= 1'b0;
    end else if (pl.mult_edge && pl.mode == cwp_pkg::CWP_M32) begin
      half <= ~half;
    end
  end

  assign count_en = pl.mult_edge && (pl.mode != cwp_pkg::CWP_M32 || half);

  // Sync edge restarts the circle so every device starts in step
  always_ff @(posedge core_clk) begin
    if (rst || pl.sync_edge) begin
      pl.phase <= 4'h0;
    end else if (count_en) begin
      pl.phase <= pl.phase + step;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_32_first;
    pl.mode == cwp_pkg::CWP_M32 && pl.mult_edge && !pl.sync_edge && !half;
  endsequence

  chk_sync_restart: assert property (pl.sync_edge |=> pl.phase == 4'h0)
    else $error("phase not restarted by sync edge");

  chk_step_16x: assert property (
    (pl.mode == cwp_pkg::CWP_M16 && pl.mult_edge && !pl.sync_edge)
      |=> pl.phase == $past(pl.phase) + 4'h1)
    else $error("16x phase did not advance one step");

  chk_div_32x: assert property (
    s_32_first |=> pl.phase == $past(pl.phase))
    else $error("32x mode advanced on an undivided edge");

endmodule
`default_nettype wire

/* File: core/cwp_clock_gen.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Two clock pins come in, a carrier multiple (32, 16, 8, 4 or 1 times) and a carrier-rate one.
// - Harmonic suppression is enabled only in the 32x, 16x and 8x modes.
// - After reset the block runs in the 16x mode.
// - In 16x mode the multiple clock walks a counter that yields sixteen even LO phases.
// - The 1x clock restarts the phase counter so all devices share a starting phase; in 1x mode it also drives the I output.
// - The 1x input may be a running clock or one pulse wider than a sixteenth period.
// - In 16x and 32x modes a cross-point routes any of the sixteen phases to each of the eight mixers.
// - Each selection step delays the LO by 22.5 degrees, a sixteenth of the period.
// - In 32x mode the input is divided by two ahead of the 16x generator.
// - In 8x and 4x modes in-phase and quadrature clocks exactly 90 degrees apart are made.
// - In 8x and 4x modes each channel gets cosine and sine weights of its chosen delay.
module cwp_clock_gen (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // CW clock pins
  input  wire logic                   cw_mult_clk,
  input  wire logic                   cw_sync_clk,
  // Serial configuration pins
  input  wire logic                   cfg_sclk,
  input  wire logic                   cfg_sdin,
  input  wire logic                   cfg_le,
  // Mixer local oscillators
  output logic [7:0]                  lo_ch,
  output logic                        quad_i,
  output logic                        quad_q,
  output logic [7:0][4:0]             w_cos,
  output logic [7:0][4:0]             w_sin,
  // Status
  output logic                        hs_en,
  output logic [2:0]                  cur_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [cwp_pkg::CWP_PIN_N-1:0]   pin_a;
  logic [cwp_pkg::CWP_PIN_N-1:0]   pin_b;
  logic [cwp_pkg::CWP_PIN_N-1:0]   pin_c;
  logic [cwp_pkg::CWP_PIN_N-1:0]   pin_rise;
  logic [cwp_pkg::CWP_PIN_N-1:0]   pins;
  logic [cwp_pkg::CWP_FRAME_W-1:0] shift;
  cwp_pkg::cwp_mode_t              mode;
  logic                            hs_req;
  logic [7:0][3:0]                 sel;
  logic [15:0]                     lo_phase;
  logic [7:0]                      lo_pick;
  logic                            route16;
  logic                            quad_mode;
  logic                            hs_ok;
  logic [3:0]                      q_phase;
  logic [2:0]                      frame_mode;

  cwp_phase_if pl ();

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Cosine of k*22.5 degrees, scaled to +/-7
  function automatic logic [4:0] cos_w(input logic [3:0] k);
    logic [4:0] w;
    w = 5'h00;
    case (k)
      4'h0:    w = 5'h07;
      4'h1:    w = 5'h06;
      4'h2:    w = 5'h05;
      4'h3:    w = 5'h03;
      4'h4:    w = 5'h00;
      4'h5:    w = 5'h1D;
      4'h6:    w = 5'h1B;
      4'h7:    w = 5'h1A;
      4'h8:    w = 5'h19;
      4'h9:    w = 5'h1A;
      4'hA:    w = 5'h1B;
      4'hB:    w = 5'h1D;
      4'hC:    w = 5'h00;
      4'hD:    w = 5'h03;
      4'hE:    w = 5'h05;
      default: w = 5'h06;
    endcase
    return w;
  endfunction

  function automatic logic mode_valid(input logic [2:0] m);
    return m <= 3'h4;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; logic reads the second stage, and the third stage only for edge detection
  assign pins = {cfg_le, cfg_sdin, cfg_sclk, cw_sync_clk, cw_mult_clk};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_a <= 5'h00;
      pin_b <= 5'h00;
      pin_c <= 5'h00;
    end else begin
      pin_a <= pins;
      pin_b <= pin_a;
      pin_c <= pin_b;
    end
  end

  assign pin_rise = pin_b & ~pin_c;

  ////////////////////////////////////////////////////////////////////////////
  // Serial configuration
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shift <= '0;
    end else if (pin_rise[cwp_pkg::CWP_PIN_SCLK]) begin
      shift <= {shift[cwp_pkg::CWP_FRAME_W-2:0], pin_b[cwp_pkg::CWP_PIN_SDIN]};
    end
  end

  assign frame_mode = shift[cwp_pkg::CWP_F_MODE +: 3];

  // Mode; an unknown code leaves the mode unchanged
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode <= cwp_pkg::CWP_MODE_RST;
    end else if (pin_rise[cwp_pkg::CWP_PIN_LE] && mode_valid(frame_mode)) begin
      mode <= cwp_pkg::cwp_mode_t'(frame_mode);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hs_req <= cwp_pkg::CWP_HS_RST;
    end else if (pin_rise[cwp_pkg::CWP_PIN_LE]) begin
      hs_req <= shift[cwp_pkg::CWP_F_HS];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int c = 0; c < cwp_pkg::CWP_CHANNELS; c++) begin
        sel[c] <= cwp_pkg::CWP_SEL_RST;
      end
    end else if (pin_rise[cwp_pkg::CWP_PIN_LE]) begin
      for (int c = 0; c < cwp_pkg::CWP_CHANNELS; c++) begin
        sel[c] <= shift[cwp_pkg::CWP_F_SEL + 4*c +: 4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase generator
  assign pl.mode      = mode;
  assign pl.mult_edge = pin_rise[cwp_pkg::CWP_PIN_MULT];
  assign pl.sync_edge = pin_rise[cwp_pkg::CWP_PIN_SYNC];

  cwp_phase_gen u_gen (
    .core_clk (core_clk),
    .rst      (rst),
    .pl       (pl.gen)
  );

  assign route16   = mode == cwp_pkg::CWP_M16 || mode == cwp_pkg::CWP_M32;
  assign quad_mode = mode == cwp_pkg::CWP_M8 || mode == cwp_pkg::CWP_M4;
  assign hs_ok     = route16 || mode == cwp_pkg::CWP_M8;

  // Phase k lags phase 0 by k sixteenths of the carrier period
  genvar k;
  generate
    for (k = 0; k < cwp_pkg::CWP_PHASES; k++) begin : g_phase
      logic [3:0] lag;
      assign lag         = pl.phase - 4'(k);
      assign lo_phase[k] = ~lag[3];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Cross-point switch and channel weights
  genvar c;
  generate
    for (c = 0; c < cwp_pkg::CWP_CHANNELS; c++) begin : g_ch
      assign lo_pick[c] = lo_phase[sel[c]];

      always_ff @(posedge core_clk) begin
        if (rst) begin
          lo_ch[c] <= 1'b0;
        end else begin
          lo_ch[c] <= route16 && lo_pick[c];
        end
      end

      // Weights stand zero while the cross-point is in use
      always_ff @(posedge core_clk) begin
        if (rst || route16) begin
          w_cos[c] <= 5'h00;
          w_sin[c] <= 5'h00;
        end else begin
          w_cos[c] <= cos_w(sel[c]);
          w_sin[c] <= cos_w(sel[c] + 4'hC);
        end
      end

      chk_xpoint_route: assert property (route16 |=> lo_ch[c] == $past(lo_pick[c]))
        else $error("channel LO does not follow its selected phase");

      chk_weight_pair: assert property (
        (mode == cwp_pkg::CWP_M8 && sel[c] == 4'h2)
          |=> w_cos[c] == 5'h05 && w_sin[c] == 5'h05)
        else $error("45 degree weights wrong");

      chk_weight_idle: assert property (
        route16 |=> w_cos[c] == 5'h00 && w_sin[c] == 5'h00)
        else $error("weights not cleared while the cross-point routes");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Quadrature clocks; 1x mode passes the carrier through on the I path
  assign q_phase = pl.phase + cwp_pkg::CWP_QUARTER;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      quad_i <= 1'b0;
      quad_q <= 1'b0;
    end else if (quad_mode) begin
      quad_i <= ~pl.phase[3];
      quad_q <= ~q_phase[3];
    end else if (mode == cwp_pkg::CWP_M1) begin
      quad_i <= pin_b[cwp_pkg::CWP_PIN_SYNC];
      quad_q <= 1'b0;
    end else begin
      quad_i <= 1'b0;
      quad_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hs_en <= 1'b0;
    end else begin
      hs_en <= hs_req && hs_ok;
    end
  end

  assign cur_mode = mode;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_quarter_in;
    quad_mode && pl.phase == 4'h4;
  endsequence

  chk_mode_reset: assert property ($past(rst) |-> mode == cwp_pkg::CWP_M16)
    else $error("mode not 16x after reset");

  chk_hs_gate: assert property (hs_en |-> $past(hs_ok))
    else $error("suppression enabled in 4x or 1x mode");

  chk_quad_90: assert property (s_quarter_in |=> quad_i && !quad_q)
    else $error("I and Q not a quarter period apart");

  chk_pulse_take: assert property (
    $rose(pin_b[cwp_pkg::CWP_PIN_SYNC]) |-> pl.sync_edge ##1 pl.phase == 4'h0)
    else $error("sync pulse not taken");

  chk_mult_edge: assert property (
    $rose(pin_b[cwp_pkg::CWP_PIN_MULT]) |-> pl.mult_edge ##1 !pl.mult_edge)
    else $error("multiple clock edge not seen once");

  chk_cfg_load: assert property (
    pin_rise[cwp_pkg::CWP_PIN_LE] |=> sel[0] == $past(shift[3:0]))
    else $error("phase selection not loaded on latch edge");

  chk_mode_keep: assert property (
    (pin_rise[cwp_pkg::CWP_PIN_LE] && !mode_valid(frame_mode)) |=> mode == $past(mode))
    else $error("unknown mode code changed the mode");

  chk_hs_off: assert property (
    (mode == cwp_pkg::CWP_M4 || mode == cwp_pkg::CWP_M1) |=> !hs_en)
    else $error("suppression left on in 4x or 1x mode");

  chk_quad_off: assert property (route16 |=> !quad_i && !quad_q)
    else $error("quadrature clocks running in a cross-point mode");

  chk_lo_off: assert property (quad_mode |=> lo_ch == 8'h00)
    else $error("cross-point LO running in a quadrature mode");

  chk_one_pass: assert property (
    mode == cwp_pkg::CWP_M1 |=> quad_i == $past(pin_b[cwp_pkg::CWP_PIN_SYNC]) && !quad_q)
    else $error("1x clock not passed on the I path");

  // Sync in a quadrature mode lands both clocks on phase zero
  sequence s_sync_quad;
    quad_mode && pl.sync_edge;
  endsequence

  chk_sync_quad: assert property (s_sync_quad ##1 quad_mode |=> quad_i && quad_q)
    else $error("quadrature clocks not restarted by sync edge");

endmodule
`default_nettype wire

/* File: verif/cwp_clk_src.sv */
`timescale 1ns/1ps
`default_nettype none
module cwp_clk_src #(
  parameter int HALF = 4
) (
  // Clock
  input  wire logic       core_clk,
  // Bench control
  input  wire logic       run,
  input  wire logic       sync_req,
  input  wire logic       sync_cont,
  input  wire logic [5:0] ratio,
  // CW clock pins
  output logic            mult_clk,
  output logic            sync_clk
);
  logic [7:0] cnt;
  logic [5:0] rc;
  logic [5:0] swid;
  logic       pend;

  always_ff @(posedge core_clk) begin
    if (!run) begin
      // Both clocks stand still between bursts
      cnt      <= 8'h00;
      rc       <= 6'h00;
      swid     <= 6'h00;
      pend     <= 1'b0;
      mult_clk <= 1'b0;
      sync_clk <= 1'b0;
    end else begin
      if (sync_req) begin
        pend <= 1'b1;
      end
      if (cnt == 8'(HALF - 1)) begin
        cnt      <= 8'h00;
        mult_clk <= ~mult_clk;
        if (!mult_clk) begin
          if (pend) begin
            sync_clk <= 1'b1;
            rc       <= 6'h01;
            swid     <= 6'h00;
            pend     <= 1'b0;
          end else begin
            rc <= (rc == ratio - 6'h01) ? 6'h00 : rc + 6'h01;
            if (sync_cont) begin
              sync_clk <= (rc < (ratio >> 1));
            end
          end
        end
      end else begin
        cnt <= cnt + 8'h01;
      end
      // Single pulse lasts ratio core cycles, above a sixteenth of the carrier
      if (!sync_cont && sync_clk) begin
        swid <= swid + 6'h01;
      end
      if (!sync_cont && swid == ratio - 6'h01) begin
        sync_clk <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/test_cwp_clock_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module test_cwp_clock_gen;
  logic            core_clk;
  logic            rst;
  logic            cw_mult_clk;
  logic            cw_sync_clk;
  logic            cfg_sclk;
  logic            cfg_sdin;
  logic            cfg_le;
  logic [7:0]      lo_ch;
  logic            quad_i;
  logic            quad_q;
  logic [7:0][4:0] w_cos;
  logic [7:0][4:0] w_sin;
  logic            hs_en;
  logic [2:0]      cur_mode;
  logic            run;
  logic            sync_req;
  logic            sync_cont;
  logic [5:0]      ratio;
  int              failures;
  int              checks_done;
  logic [4:0]      cos_t [16];

  cwp_clock_gen u_dut (.core_clk(core_clk), .rst(rst), .cw_mult_clk(cw_mult_clk),
    .cw_sync_clk(cw_sync_clk), .cfg_sclk(cfg_sclk), .cfg_sdin(cfg_sdin), .cfg_le(cfg_le),
    .lo_ch(lo_ch), .quad_i(quad_i), .quad_q(quad_q), .w_cos(w_cos), .w_sin(w_sin),
    .hs_en(hs_en), .cur_mode(cur_mode));

  cwp_clk_src u_src (.core_clk(core_clk), .run(run), .sync_req(sync_req),
    .sync_cont(sync_cont), .ratio(ratio), .mult_clk(cw_mult_clk), .sync_clk(cw_sync_clk));

  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Frame goes out msb first, then latch enable loads it
  task automatic cfg_load(input logic [2:0] mode, input logic hs, input logic [31:0] sel);
    logic [35:0] frame;
    frame = {mode, hs, sel};
    for (int b = 35; b >= 0; b--) begin
      cfg_sdin = frame[b];
      tick(3);
      cfg_sclk = 1'b1;
      tick(3);
      cfg_sclk = 1'b0;
    end
    cfg_le = 1'b1;
    tick(3);
    cfg_le = 1'b0;
    tick(6);
  endtask

  task automatic start(input logic cont, input logic [5:0] rat);
    sync_cont = cont;
    ratio = rat;
    run = 1'b1;
    sync_req = 1'b1;
    tick(1);
    sync_req = 1'b0;
  endtask

  task automatic stop();
    run = 1'b0;
    tick(4);
  endtask

  task automatic next_rise();
    @(posedge cw_mult_clk);
    tick(5);
  endtask

  function automatic logic [7:0] exp_lo(input logic [3:0] p, input logic [31:0] sel);
    logic [3:0] d;
    logic [7:0] e;
    for (int c = 0; c < 8; c++) begin
      d = p - sel[4*c+:4];
      e[c] = ~d[3];
    end
    return e;
  endfunction

  task automatic t_reset();
    chk("cur_mode", cwp_pkg::CWP_M16, cur_mode);
    chk("hs_en", 1'b1, hs_en);
    chk("lo_ch", exp_lo(4'h0, 32'h0000_0000), lo_ch);
  endtask

  task automatic t_modes();
    cwp_pkg::cwp_mode_t m [5];
    m = '{cwp_pkg::CWP_M16, cwp_pkg::CWP_M32, cwp_pkg::CWP_M8, cwp_pkg::CWP_M4, cwp_pkg::CWP_M1};
    for (int i = 0; i < 5; i++) begin
      cfg_load(m[i], 1'b1, 32'h0000_0000);
      chk("cur_mode", m[i], cur_mode);
      chk("hs_en", i < 3, hs_en);
    end
    cfg_load(3'h7, 1'b1, 32'h0000_0000);
    chk("cur_mode", cwp_pkg::CWP_M1, cur_mode);
    cfg_load(cwp_pkg::CWP_M16, 1'b0, 32'h0000_0000);
    chk("hs_en", 1'b0, hs_en);
  endtask

  task automatic t_lo16();
    cfg_load(cwp_pkg::CWP_M16, 1'b1, 32'hfdb9_7531);
    start(1'b1, 6'h10);
    for (int r = 0; r < 20; r++) begin
      next_rise();
      chk("lo_ch", exp_lo(4'(r), 32'hfdb9_7531), lo_ch);
    end
    chk("quad_i", 1'b0, quad_i);
    chk("w_cos", 5'h00, w_cos[7]);
    stop();
  endtask

  task automatic t_lo32();
    cfg_load(cwp_pkg::CWP_M32, 1'b1, 32'heca8_6420);
    start(1'b0, 6'h20);
    for (int r = 0; r < 14; r++) begin
      next_rise();
      if (r % 2 == 0) begin
        chk("lo_ch", exp_lo(4'(r / 2), 32'heca8_6420), lo_ch);
      end
    end
    stop();
  endtask

  task automatic t_quad(input logic [2:0] mode, input int step, input logic [31:0] sel);
    logic [3:0] p;
    cfg_load(mode, 1'b1, sel);
    start(1'b0, 6'h10);
    for (int r = 0; r < 8; r++) begin
      next_rise();
      p = 4'(r * step);
      chk("quad_i", !p[3], quad_i);
      p = p + 4'h4;
      chk("quad_q", !p[3], quad_q);
      chk("lo_ch", 8'h00, lo_ch);
    end
    for (int c = 0; c < 8; c++) begin
      chk("w_cos", cos_t[sel[4*c+:4]], w_cos[c]);
      chk("w_sin", cos_t[4'(sel[4*c+:4] + 4'hc)], w_sin[c]);
    end
    stop();
  endtask

  task automatic t_one();
    cfg_load(cwp_pkg::CWP_M1, 1'b1, 32'h0000_0000);
    start(1'b1, 6'h02);
    for (int r = 0; r < 6; r++) begin
      next_rise();
      chk("quad_i", r % 2 == 0, quad_i);
      chk("quad_q", 1'b0, quad_q);
    end
    chk("w_cos", cos_t[0], w_cos[0]);
    chk("w_sin", cos_t[12], w_sin[0]);
    stop();
  endtask

  task automatic final_report();
    $display("Checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #500000;
    failures++;
    final_report();
  end

  initial begin
    cos_t = '{5'h07, 5'h06, 5'h05, 5'h03, 5'h00, 5'h1d, 5'h1b, 5'h1a,
              5'h19, 5'h1a, 5'h1b, 5'h1d, 5'h00, 5'h03, 5'h05, 5'h06};
    failures = 0;
    checks_done = 0;
    rst = 1'b1;
    cfg_sclk = 1'b0;
    cfg_sdin = 1'b0;
    cfg_le = 1'b0;
    run = 1'b0;
    sync_req = 1'b0;
    sync_cont = 1'b0;
    ratio = 6'h10;
    tick(12);
    rst = 1'b0;
    tick(3);
    t_reset();
    t_modes();
    t_lo16();
    t_lo32();
    t_quad(cwp_pkg::CWP_M8, 2, 32'heca8_6420);
    t_quad(cwp_pkg::CWP_M4, 4, 32'hfdb9_7531);
    t_one();
    final_report();
  end
endmodule
`default_nettype wire
